// ==== hw/wdcr_pkg.sv ====
// Behaviour
// R1 - Host software sets the watchdog period through the firmware call with sub-function 2, passing the time-out value as a byte.
// R2 - A configuration setting selects the length of one time-out count unit.
// R3 - Loading a non-zero value starts the count down from that value at the selected unit rate.
// R4 - When the running count reaches zero the watchdog fires a recovery action.
// R5 - The recovery action is either a cold system reset or a non-maskable interrupt, as configured.
// R6 - Host software reloads the value periodically, and each reload restarts the count from the new value.
// R7 - Loading zero disables the watchdog, stops the count and suppresses the expiry action.
// R8 - Host software refreshes with at least a ten percent margin below the time-out.
// R9 - Host software loads zero before a supervised program ends.
// R10 - The time-out value is an 8-bit count from 1 to 255 units, zero meaning disabled.
package wdcr_pkg;
  localparam int unsigned WDCR_CLK_HZ = 20000000;
  localparam int unsigned WDCR_UNIT_SEC = 1;
  localparam int unsigned WDCR_UNIT_MIN_SEC = 60;
  localparam int unsigned WDCR_SEC_CYCLES = WDCR_CLK_HZ * WDCR_UNIT_SEC;
  localparam int unsigned WDCR_MIN_CYCLES = WDCR_CLK_HZ * WDCR_UNIT_MIN_SEC;
  localparam int unsigned WDCR_CNT_W = 8;
  localparam int unsigned WDCR_PRE_W = 31;
  localparam logic [7:0] WDCR_CNT_RST = 8'h00;
  localparam int unsigned WDCR_RESET_PULSE_CYCLES = 16;
  typedef enum logic [2:0] {
    WDCR_IDLE = 3'b001,
    WDCR_RUN = 3'b010,
    WDCR_FIRED = 3'b100
  } wdcr_state_e;
endpackage

// ==== hw/wdcr_prescale.sv ====
`timescale 1ns/1ns
module wdcr_prescale
  import wdcr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = WDCR_SEC_CYCLES,
  parameter int unsigned MIN_CYCLES = WDCR_MIN_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_restart,
  input wire logic i_unit_min,
  output logic o_tick
);
  logic [WDCR_PRE_W-1:0] pre_ff;
  logic [WDCR_PRE_W-1:0] nxt_pre;
  logic [WDCR_PRE_W-1:0] last;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    // Unit chosen by configuration
    last = i_unit_min ? WDCR_PRE_W'(MIN_CYCLES - 1) : WDCR_PRE_W'(SEC_CYCLES - 1); // R2
    nxt_pre = pre_ff + 1'b1;
    nxt_tick = 1'b0;
    if (i_restart) begin
      nxt_pre = '0;
    end else if (pre_ff >= last) begin
      nxt_pre = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else if (i_ce) begin
      pre_ff <= nxt_pre;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;
endmodule

// ==== hw/wdcr_top.sv ====
`timescale 1ns/1ns
module wdcr_top
  import wdcr_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = WDCR_SEC_CYCLES,
  parameter int unsigned MIN_CYCLES = WDCR_MIN_CYCLES,
  parameter int unsigned RESET_PULSE_CYCLES = WDCR_RESET_PULSE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [WDCR_CNT_W-1:0] i_timeout,
  input wire logic i_unit_min,
  input wire logic i_action_nmi,
  output logic o_running,
  output logic [WDCR_CNT_W-1:0] o_count,
  output logic o_expired,
  output logic o_sys_reset,
  output logic o_nmi
);
  wdcr_state_e state_ff;
  wdcr_state_e nxt_state;
  logic [WDCR_CNT_W-1:0] cnt_ff;
  logic [WDCR_CNT_W-1:0] nxt_cnt;
  logic running_ff;
  logic nxt_running;
  logic expired_ff;
  logic nxt_expired;
  logic rst_ff;
  logic nxt_rst;
  logic nmi_ff;
  logic nxt_nmi;
  logic [7:0] rst_len_ff;
  logic [7:0] nxt_rst_len;
  logic tick;
  logic restart;
  logic expire_now;

  // A zero time-out is the host's request to switch the watchdog off
  function automatic logic is_off(input logic [WDCR_CNT_W-1:0] value);
    return value == WDCR_CNT_RST;
  endfunction

  // Prescaler restarts on every load so the first unit is a full one
  assign restart = i_load | (state_ff != WDCR_RUN);

  wdcr_prescale #(
    .SEC_CYCLES(SEC_CYCLES),
    .MIN_CYCLES(MIN_CYCLES)
  ) i_wdcr_prescale (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_restart(restart),
    .i_unit_min(i_unit_min),
    .o_tick(tick)
  );

  // Expiry is decoded once so the flag, the interrupt and the reset pulse agree
  // A load in the same cycle as the last tick cancels the expiry
  always_comb begin
    expire_now = 1'b0;
    if (state_ff == WDCR_RUN && !i_load && tick && cnt_ff == 8'h01) begin
      expire_now = 1'b1; // R4
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      WDCR_IDLE, WDCR_FIRED: begin
        if (i_load && !is_off(i_timeout)) begin
          nxt_state = WDCR_RUN; // R3
        end else if (i_load) begin
          nxt_state = WDCR_IDLE; // R7
        end
      end
      WDCR_RUN: begin
        if (i_load && is_off(i_timeout)) begin
          nxt_state = WDCR_IDLE; // R7
        end else if (expire_now) begin
          nxt_state = WDCR_FIRED; // R4
        end
      end
      // Only a corrupted one-hot code lands here
      default: begin
        nxt_state = WDCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_ff <= WDCR_IDLE;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  // A zero load leaves the count at zero, matching the idle state
  always_comb begin
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      WDCR_IDLE, WDCR_FIRED: begin
        if (i_load) begin
          nxt_cnt = i_timeout; // R10
        end
      end
      WDCR_RUN: begin
        // A reload wins over a tick that lands in the same cycle
        if (i_load) begin
          nxt_cnt = i_timeout; // R6
        end else if (tick) begin
          nxt_cnt = cnt_ff - 8'h01; // R3
        end
      end
      default: begin
        nxt_cnt = WDCR_CNT_RST;
      end
    endcase
    nxt_running = (nxt_state == WDCR_RUN);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cnt_ff <= WDCR_CNT_RST;
      running_ff <= 1'b0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
      running_ff <= nxt_running;
    end
  end

  always_comb begin
    nxt_expired = expire_now; // R4
    // Action is picked at expiry, so the host may switch it while counting
    nxt_nmi = expire_now & i_action_nmi; // R5
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      expired_ff <= 1'b0;
      nmi_ff <= 1'b0;
    end else if (i_ce) begin
      expired_ff <= nxt_expired;
      nmi_ff <= nxt_nmi;
    end
  end

  // The pulse is stretched so the board's reset logic sees a clean level;
  // a freeze through the clock enable stretches it further
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rst_len = rst_len_ff;
    if (expire_now && !i_action_nmi) begin
      nxt_rst = 1'b1; // R5
      nxt_rst_len = 8'(RESET_PULSE_CYCLES - 1);
    end else if (rst_len_ff != 8'h00) begin
      nxt_rst_len = rst_len_ff - 8'h01;
    end else begin
      nxt_rst = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rst_ff <= 1'b0;
      rst_len_ff <= 8'h00;
    end else if (i_ce) begin
      rst_ff <= nxt_rst;
      rst_len_ff <= nxt_rst_len;
    end
  end

  assign o_running = running_ff;
  assign o_count = cnt_ff;
  assign o_expired = expired_ff;
  assign o_sys_reset = rst_ff;
  assign o_nmi = nmi_ff;
endmodule

// ==== testbench/wdcr_chk.sv ====
`timescale 1ns/1ns
module wdcr_chk
  import wdcr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [WDCR_CNT_W-1:0] i_timeout,
  input wire logic i_action_nmi,
  input wire logic o_running,
  input wire logic [WDCR_CNT_W-1:0] o_count,
  input wire logic o_expired,
  input wire logic o_sys_reset,
  input wire logic o_nmi
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_take;
    i_ce && i_load;
  endsequence
  a_load_start: assert property (s_take ##0 i_timeout != 8'h00 |=>
    o_running && o_count == $past(i_timeout)) else $error("load not taken");
  a_load_zero: assert property (s_take ##0 i_timeout == 8'h00 |=>
    !o_running && o_count == 8'h00) else $error("zero load left it running");
  a_count_step: assert property (o_running && !$past(i_load) |->
    o_count == $past(o_count) || o_count + 8'h01 == $past(o_count)) else $error("bad count step");
  a_expire_idle: assert property (o_expired |->
    !o_running && o_count == 8'h00) else $error("expiry while counting");
  a_action_one: assert property (o_expired |->
    o_nmi || o_sys_reset) else $error("expiry without action");
  a_nmi_cause: assert property (o_nmi |-> o_expired) else $error("stray nmi");
  a_reset_hold: assert property ($rose(o_sys_reset) |->
    o_sys_reset[*8]) else $error("reset pulse too short");
  a_action_pick: assert property ($rose(o_expired) |->
    o_nmi == $past(i_action_nmi)) else $error("wrong expiry action");
endmodule
bind wdcr_top wdcr_chk i_wdcr_chk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_ce(i_ce), .i_load(i_load), .i_timeout(i_timeout), .i_action_nmi(i_action_nmi),
  .o_running(o_running),
  .o_count(o_count), .o_expired(o_expired), .o_sys_reset(o_sys_reset), .o_nmi(o_nmi));

// ==== testbench/wdcr_top_test.sv ====
`timescale 1ns/1ns
module wdcr_top_test;
  import wdcr_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, ld = 0, umin = 0, act = 0;
  logic [7:0] tmo = 8'h00;
  logic run, ex, srst, nmi;
  logic [7:0] cnt;
  int bad_count = 0, num_checks = 0, cyc = 0, n;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("Error %s expected %0h seen %0h", nm, e, g); bad_count++; end end
  // Short unit counts keep each expiry within a few dozen cycles
  wdcr_top #(.SEC_CYCLES(10), .MIN_CYCLES(30)) i_wdcr_top (.i_sys_clk(clk),
    .i_reset_n(rst_n), .i_ce(ce), .i_load(ld), .i_timeout(tmo), .i_unit_min(umin),
    .i_action_nmi(act), .o_running(run), .o_count(cnt), .o_expired(ex),
    .o_sys_reset(srst), .o_nmi(nmi));
  initial forever #25 clk = ~clk;
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task load(input logic [7:0] t);
    @(posedge clk) #5;
    ld = 1;
    tmo = t;
    @(posedge clk) #5;
    ld = 0;
  endtask
  task wait_exp(input int lim);
    n = 0;
    while (ex !== 1'b1 && n < lim) begin
      @(posedge clk) #5;
      n++;
    end
  endtask
  task t_cold();
    load(8'h03);
    `CHK("count", 8'h03, cnt)
    wait_exp(60);
    `CHK("delay", 1'b1, n >= 29 && n <= 32)
    `CHK("cold", 1'b1, srst)
    `CHK("nmi", 1'b0, nmi)
    `CHK("running", 1'b0, run)
    `CHK("count", 8'h00, cnt)
    n = 0;
    while (srst === 1'b1 && n < 40) begin
      @(posedge clk) #5;
      n++;
    end
    `CHK("pulse", WDCR_RESET_PULSE_CYCLES, n)
    $display("test cold done");
  endtask
  task t_nmi_min();
    umin = 1;
    act = 1;
    load(8'h01);
    wait_exp(60);
    `CHK("delay", 1'b1, n >= 29 && n <= 32)
    `CHK("nmi", 1'b1, nmi)
    `CHK("cold", 1'b0, srst)
    umin = 0;
    $display("test nmi_min done");
  endtask
  task t_reload();
    load(8'h02);
    repeat (15) @(posedge clk);
    load(8'h02);
    `CHK("count", 8'h02, cnt)
    wait_exp(40);
    `CHK("delay", 1'b1, n >= 19 && n <= 22)
    $display("test reload done");
  endtask
  task t_freeze();
    load(8'h01);
    ce = 0;
    repeat (30) begin
      @(posedge clk) #5;
    end
    `CHK("frozen", 1'b1, run && cnt == 8'h01)
    ce = 1;
    wait_exp(40);
    `CHK("delay", 1'b1, n >= 9 && n <= 12)
    $display("test freeze done");
  endtask
  task t_disable();
    load(8'hFF);
    `CHK("count", 8'hFF, cnt)
    load(8'h02);
    load(8'h00);
    `CHK("running", 1'b0, run)
    `CHK("count", 8'h00, cnt)
    wait_exp(40);
    `CHK("expired", 1'b0, ex)
    $display("test disable done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #5 rst_n = 1;
    t_cold();
    t_nmi_min();
    t_reload();
    t_freeze();
    t_disable();
    tally_and_finish();
  end
endmodule
